/* File: alu_exec_monitor.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checker for the execution datapath
// ----------------------------------------------------------------
module alu_exec_monitor (
	// Clock and reset
	input wire logic                      core_clk,
	input wire logic                      rst_b,
	// Issue port
	input wire logic                      issueValid,
	input wire alu_exec_pkg::addr_mode_t  issueMode,
	input wire logic                      toMemory,
	input wire logic [11:0]               issuePc,
	input wire logic                      issueReady,
	input wire logic                      done,
	// Memories
	input wire logic [11:0]               romAddr,
	input wire logic                      dataRead,
	input wire logic                      dataWrite,
	// Architectural state
	input wire logic [7:0]                accumulator,
	input wire logic                      zeroFlag,
	input wire logic                      carryFlag
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	wire taken = issueValid && issueReady;

	a_retire_four_cycles: assert property (taken |-> ##4 done)
		else $error("done not four cycles after issue");
	a_busy_not_ready: assert property (taken |=> !issueReady [*3])
		else $error("ready while busy");
	a_done_single: assert property (done |=> !done)
		else $error("done longer than one cycle");
	a_done_has_cause: assert property (done |-> issueReady && $past(taken, 4))
		else $error("done without issue four cycles earlier");
	a_operand_fetch_order: assert property (taken |=> romAddr == $past(issuePc) + 12'h001
		##1 romAddr == $past(issuePc, 2) + 12'h002)
		else $error("operand bytes not fetched after opcode");
	a_write_slot: assert property (dataWrite |-> $past(taken, 3))
		else $error("data write outside write cycle");
	a_imm_no_ram: assert property (taken && issueMode == alu_exec_pkg::MODE_IMMEDIATE
		&& !toMemory |=> !dataRead [*3])
		else $error("immediate operand read from data memory");
	a_state_at_retire: assert property ($changed({accumulator, zeroFlag, carryFlag})
		|-> done)
		else $error("accumulator or flags changed before retirement");
endmodule

bind core_load_store_alu_exec alu_exec_monitor mon (.core_clk, .rst_b, .issueValid, .issueMode,
	.toMemory, .issuePc, .issueReady, .done, .romAddr, .dataRead, .dataWrite, .accumulator,
	.zeroFlag, .carryFlag);

/* File: alu_exec_pkg.sv */
// What this block does
// - Forty operations, nine modes, 244 opcodes.
// - Decoder sorts operations into two of the six groups.
// - Load/store length one to three bytes.
// - Plain load/store moves accumulator and memory.
// - Immediate load into accumulator or memory.
// - Sum/conj/compare/difference use accumulator operand.
// - Zero/plus/minus reach any data address.
// - Invert/rotate/shift act on accumulator only.
// - Two pointers, four short-direct registers.
// - Immediates come from program ROM only.
// - Pointers and short registers at 80h-83h.
// - Opcode bit 4 selects indirect pointer.
package alu_exec_pkg;

	// ----------------------------------------------------------------
	// Operations, groups and addressing modes
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_MOVE_BYTE, OP_LOAD_IMMEDIATE, OP_SUM, OP_CONJ, OP_COMPARE, OP_DIFFERENCE,
		OP_ZERO_OPERAND, OP_PLUS_ONE, OP_MINUS_ONE, OP_INVERT_ACCUMULATOR,
		OP_ROTATE_LEFT_THROUGH_CARRY, OP_SHIFT_LEFT, OP_NONE
	} alu_op_t;

	typedef enum logic [2:0] {
		GRP_LOAD_STORE, GRP_ARITH_LOGIC, GRP_COND_BRANCH, GRP_CONTROL,
		GRP_JUMP_CALL, GRP_BIT_MANIP
	} op_group_t;

	typedef enum logic [3:0] {
		MODE_IMMEDIATE, MODE_DIRECT, MODE_SHORT_DIRECT, MODE_EXTENDED, MODE_PC_RELATIVE,
		MODE_BIT_DIRECT, MODE_BIT_TEST, MODE_INDIRECT, MODE_INHERENT
	} addr_mode_t;

	// ----------------------------------------------------------------
	// Architectural constants
	// ----------------------------------------------------------------
	localparam int        BASIC_OP_COUNT   = 40;
	localparam int        VALID_OPCODES    = 244;
	localparam int        EXEC_CYCLES      = 4;
	localparam logic [7:0] PTR_X_ADDR      = 8'h80;
	localparam logic [7:0] PTR_Y_ADDR      = 8'h81;
	localparam logic [7:0] SHORT_V_ADDR    = 8'h82;
	localparam logic [7:0] SHORT_W_ADDR    = 8'h83;
	localparam logic [7:0] ACC_ADDR        = 8'hff;
	localparam int        PTR_SEL_BIT      = 4;
	localparam logic [7:0] ACC_RESET       = 8'h00;

endpackage

/* File: core_load_store_alu_exec.sv */
`timescale 1ns/1ps
// --------------------------------------------------------------------
// Execution datapath for load/store and arithmetic/logic instructions
// --------------------------------------------------------------------
// The controller presents a decoded instruction on issueValid. The block
// fetches any operand bytes from program ROM, reads and writes the data
// space, and retires after exactly four cycles. Program and data memory
// answer combinationally in the cycle of the request.
module core_load_store_alu_exec (
	// Clock and reset
	input  wire logic                    core_clk,
	input  wire logic                    rst_b,
	// Issue port
	input  wire logic                    issueValid,
	input  wire alu_exec_pkg::alu_op_t   issueOp,
	input  wire alu_exec_pkg::addr_mode_t issueMode,
	input  wire logic [7:0]              issueOpcode,
	input  wire logic                    toMemory,
	input  wire logic [1:0]              shortSel,
	input  wire logic [11:0]             issuePc,
	output logic                         issueReady,
	output logic                         done,
	output logic [1:0]                   instrBytes,
	output alu_exec_pkg::op_group_t      opGroup,
	// Program ROM
	output logic [11:0]                  romAddr,
	input  wire logic [7:0]              romData,
	// Data space
	output logic [7:0]                   dataAddr,
	output logic                         dataRead,
	input  wire logic [7:0]              dataRdata,
	output logic                         dataWrite,
	output logic [7:0]                   dataWdata,
	// Architectural state
	output logic [7:0]                   accumulator,
	output logic                         zeroFlag,
	output logic                         carryFlag
);

	typedef enum logic [1:0] {S_IDLE, S_FETCH, S_READ, S_WRITE} state_t;

	state_t                   state_q;
	state_t                   state_d;
	alu_exec_pkg::alu_op_t    op_q;
	alu_exec_pkg::addr_mode_t mode_q;
	logic [7:0]               opcode_q;
	logic                     toMem_q;
	logic [1:0]               short_q;
	logic [11:0]              pc_q;
	logic [7:0]               imm_q;
	logic [7:0]               addr_q;
	logic [7:0]               mem_q;
	logic [7:0]               acc_q;
	logic                     z_q;
	logic                     c_q;
	logic                     done_q;
	logic [1:0]               len_q;

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	function automatic logic [1:0] op_length(input alu_exec_pkg::alu_op_t op,
			input alu_exec_pkg::addr_mode_t mode, input logic mem);
		logic [1:0] n;
		n = 2'h1;
		case (mode)
			alu_exec_pkg::MODE_DIRECT:    n = 2'h2;
			alu_exec_pkg::MODE_IMMEDIATE: n = (op == alu_exec_pkg::OP_LOAD_IMMEDIATE && mem) ?
				2'h3 : 2'h2;
			default:                      n = 2'h1;
		endcase
		if (op == alu_exec_pkg::OP_ZERO_OPERAND && mode == alu_exec_pkg::MODE_DIRECT && mem)
			n = 2'h3;
		if (op == alu_exec_pkg::OP_ZERO_OPERAND && !mem)
			n = 2'h2;
		if (op == alu_exec_pkg::OP_SHIFT_LEFT)
			n = 2'h2;
		return n;
	endfunction

	function automatic logic [1:0] short_addr_lo(input logic [1:0] sel);
		return sel;
	endfunction

	// ----------------------------------------------------------------
	// Decode of the issued and the latched instruction
	// ----------------------------------------------------------------
	wire logic [1:0] issueLen = op_length(issueOp, issueMode, toMemory);
	wire logic immNeeded = (mode_q == alu_exec_pkg::MODE_IMMEDIATE) ||
		(mode_q == alu_exec_pkg::MODE_DIRECT);
	wire logic [7:0] ptrAddr = opcode_q[alu_exec_pkg::PTR_SEL_BIT] ?
		alu_exec_pkg::PTR_Y_ADDR : alu_exec_pkg::PTR_X_ADDR;
	wire logic [7:0] shortAddr = {alu_exec_pkg::PTR_X_ADDR[7:2], short_addr_lo(short_q)};
	wire logic accOnly = (op_q == alu_exec_pkg::OP_INVERT_ACCUMULATOR) ||
		(op_q == alu_exec_pkg::OP_ROTATE_LEFT_THROUGH_CARRY) ||
		(op_q == alu_exec_pkg::OP_SHIFT_LEFT) ||
		(op_q == alu_exec_pkg::OP_ZERO_OPERAND && !toMem_q);
	wire logic immToMem = op_q == alu_exec_pkg::OP_LOAD_IMMEDIATE && toMem_q;
	wire logic isStore = op_q == alu_exec_pkg::OP_MOVE_BYTE && toMem_q;
	wire logic isRmw = toMem_q && (op_q == alu_exec_pkg::OP_PLUS_ONE ||
		op_q == alu_exec_pkg::OP_MINUS_ONE || op_q == alu_exec_pkg::OP_ZERO_OPERAND);
	wire logic needsRead = !accOnly && mode_q != alu_exec_pkg::MODE_IMMEDIATE &&
		!isStore && !immToMem && op_q != alu_exec_pkg::OP_ZERO_OPERAND;
	wire logic needsWrite = isStore || immToMem || isRmw;
	wire logic [7:0] effAddr = (mode_q == alu_exec_pkg::MODE_INDIRECT) ? mem_q :
		(mode_q == alu_exec_pkg::MODE_SHORT_DIRECT) ? shortAddr : addr_q;

	// ----------------------------------------------------------------
	// Arithmetic unit
	// ----------------------------------------------------------------
	wire logic [7:0] operand = (mode_q == alu_exec_pkg::MODE_IMMEDIATE) ? imm_q : mem_q;
	wire logic [8:0] sumW = {1'b0, acc_q} + {1'b0, operand};
	wire logic [8:0] difW = {1'b0, acc_q} - {1'b0, operand};
	logic [7:0] res;
	logic       resC;
	logic       wrAcc;
	logic       updZ;
	logic       updC;

	always_comb begin
		res = acc_q;
		resC = c_q;
		wrAcc = 1'b0;
		updZ = 1'b1;
		updC = 1'b1;
		case (op_q)
			alu_exec_pkg::OP_MOVE_BYTE: begin
				res = toMem_q ? acc_q : operand;
				wrAcc = !toMem_q;
				updC = 1'b0;
			end
			alu_exec_pkg::OP_LOAD_IMMEDIATE: begin
				res = imm_q;
				wrAcc = !toMem_q;
				updZ = !toMem_q;
				updC = 1'b0;
			end
			alu_exec_pkg::OP_SUM: begin
				res = sumW[7:0];
				resC = sumW[8];
				wrAcc = 1'b1;
			end
			alu_exec_pkg::OP_CONJ: begin
				res = acc_q & operand;
				resC = 1'b0;
				wrAcc = 1'b1;
			end
			alu_exec_pkg::OP_COMPARE: begin
				res = difW[7:0];
				resC = difW[8];
			end
			alu_exec_pkg::OP_DIFFERENCE: begin
				res = difW[7:0];
				resC = difW[8];
				wrAcc = 1'b1;
			end
			alu_exec_pkg::OP_ZERO_OPERAND: begin
				res = 8'h00;
				resC = 1'b0;
				wrAcc = !toMem_q;
				updZ = !toMem_q;
				updC = !toMem_q;
			end
			alu_exec_pkg::OP_PLUS_ONE: begin
				res = (toMem_q ? operand : acc_q) + 8'h01;
				wrAcc = !toMem_q;
				updC = 1'b0;
			end
			alu_exec_pkg::OP_MINUS_ONE: begin
				res = (toMem_q ? operand : acc_q) - 8'h01;
				wrAcc = !toMem_q;
				updC = 1'b0;
			end
			alu_exec_pkg::OP_INVERT_ACCUMULATOR: begin
				res = ~acc_q;
				resC = acc_q[7];
				wrAcc = 1'b1;
			end
			alu_exec_pkg::OP_ROTATE_LEFT_THROUGH_CARRY: begin
				res = {acc_q[6:0], c_q};
				resC = acc_q[7];
				wrAcc = 1'b1;
			end
			alu_exec_pkg::OP_SHIFT_LEFT: begin
				res = {acc_q[6:0], 1'b0};
				resC = acc_q[7];
				wrAcc = 1'b1;
			end
			default: begin
				updZ = 1'b0;
				updC = 1'b0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Sequencer: fetch, read, write, each slot one machine cycle
	// ----------------------------------------------------------------
	// Fixed four-cycle timing keeps retirement independent of mode.
	always_comb begin
		state_d = state_q;
		case (state_q)
			S_IDLE:  if (issueValid) state_d = S_FETCH;
			S_FETCH: state_d = S_READ;
			S_READ:  state_d = S_WRITE;
			S_WRITE: state_d = S_IDLE;
			default: state_d = S_IDLE;
		endcase
	end

	// Operand bytes follow the opcode in program ROM; data RAM never supplies one.
	assign romAddr = (state_q == S_FETCH) ? pc_q + 12'h001 :
		(state_q == S_READ) ? pc_q + 12'h002 : pc_q;
	assign dataRead = (state_q == S_FETCH && mode_q == alu_exec_pkg::MODE_INDIRECT) ||
		(state_q == S_READ && needsRead);
	assign dataAddr = (state_q == S_FETCH) ? ptrAddr : effAddr;
	assign dataWrite = (state_q == S_WRITE) && needsWrite;
	assign dataWdata = res;
	assign issueReady = (state_q == S_IDLE);
	assign done = done_q;
	assign instrBytes = len_q;
	assign accumulator = acc_q;
	assign zeroFlag = z_q;
	assign carryFlag = c_q;
	// Only the two groups executed here are ever reported; the others never reach this block.
	assign opGroup = (op_q == alu_exec_pkg::OP_MOVE_BYTE ||
		op_q == alu_exec_pkg::OP_LOAD_IMMEDIATE) ?
		alu_exec_pkg::GRP_LOAD_STORE : alu_exec_pkg::GRP_ARITH_LOGIC;

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			state_q <= S_IDLE;
			op_q <= alu_exec_pkg::OP_NONE;
			mode_q <= alu_exec_pkg::MODE_INHERENT;
			opcode_q <= 8'h00;
			toMem_q <= 1'b0;
			short_q <= 2'h0;
			pc_q <= 12'h000;
			imm_q <= 8'h00;
			addr_q <= 8'h00;
			mem_q <= 8'h00;
			acc_q <= alu_exec_pkg::ACC_RESET;
			z_q <= 1'b0;
			c_q <= 1'b0;
			done_q <= 1'b0;
			len_q <= 2'h0;
		end else begin
			state_q <= state_d;
			done_q <= (state_q == S_WRITE);
			if (state_q == S_IDLE && issueValid) begin
				op_q <= issueOp;
				mode_q <= issueMode;
				opcode_q <= issueOpcode;
				toMem_q <= toMemory;
				short_q <= shortSel;
				pc_q <= issuePc;
				len_q <= issueLen;
			end
			if (state_q == S_FETCH) begin
				if (immNeeded) begin
					imm_q <= romData;
					addr_q <= romData;
				end
				if (mode_q == alu_exec_pkg::MODE_INDIRECT)
					mem_q <= dataRdata;
			end
			if (state_q == S_READ) begin
				if (immToMem)
					imm_q <= romData;
				if (needsRead)
					mem_q <= dataRdata;
			end
			if (state_q == S_WRITE) begin
				if (wrAcc)
					acc_q <= res;
				if (updZ)
					z_q <= (res == 8'h00);
				if (updC)
					c_q <= resC;
			end
		end
	end

endmodule

/* File: core_load_store_alu_exec_test.sv */
`timescale 1ns/1ps
module core_load_store_alu_exec_test;
	logic                       core_clk = 1'b0;
	logic                       rst_b = 1'b0;
	logic                       issueValid = 1'b0;
	alu_exec_pkg::alu_op_t      issueOp = alu_exec_pkg::OP_NONE;
	alu_exec_pkg::addr_mode_t   issueMode = alu_exec_pkg::MODE_IMMEDIATE;
	logic [7:0]                 issueOpcode = 8'h00;
	logic                       toMemory = 1'b0;
	logic [1:0]                 shortSel = 2'h0;
	logic [11:0]                issuePc = 12'h000;
	logic                       issueReady, done, dataRead, dataWrite, zeroFlag, carryFlag;
	logic [1:0]                 instrBytes;
	alu_exec_pkg::op_group_t    opGroup;
	logic [11:0]                romAddr;
	logic [7:0]                 romData, dataAddr, dataRdata, dataWdata, accumulator;
	logic [11:0]                pc = 12'h010;
	int                         errors = 0;
	int                         compares = 0;

	always #2 core_clk = ~core_clk;

	core_load_store_alu_exec DUT (.core_clk, .rst_b, .issueValid, .issueOp, .issueMode,
		.issueOpcode, .toMemory, .shortSel, .issuePc, .issueReady, .done, .instrBytes,
		.opGroup, .romAddr, .romData, .dataAddr, .dataRead, .dataRdata, .dataWrite,
		.dataWdata, .accumulator, .zeroFlag, .carryFlag);
	mem_partner mem (.core_clk, .romAddr, .romData, .dataAddr, .dataRead, .dataRdata,
		.dataWrite, .dataWdata);

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic test_done;
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Operation and mode codes are the package enums in declaration order.
	// A byte count of zero skips the length check.
	task automatic run(input logic [3:0] op, input logic [3:0] md, input logic [7:0] b1,
		input logic [7:0] b2, input logic tm, input logic [1:0] sh, input logic [7:0] opc,
		input logic [1:0] nb, input logic [7:0] ea, input logic ez, input logic ec);
		int n = 0;
		alu_exec_pkg::op_group_t grp;
		mem.rom[pc + 12'h001] = b1;
		mem.rom[pc + 12'h002] = b2;
		@(posedge core_clk);
		issueValid <= 1'b1;
		issueOp <= alu_exec_pkg::alu_op_t'(op);
		issueMode <= alu_exec_pkg::addr_mode_t'(md);
		{issueOpcode, toMemory, shortSel, issuePc} <= {opc, tm, sh, pc};
		@(posedge core_clk);
		issueValid <= 1'b0;
		while (done !== 1'b1 && n < 9) begin
			@(posedge core_clk);
			n++;
		end
		grp = (op < 4'h2) ? alu_exec_pkg::GRP_LOAD_STORE : alu_exec_pkg::GRP_ARITH_LOGIC;
		chk("cycles", 8'(alu_exec_pkg::EXEC_CYCLES), 8'(n));
		chk("group", 8'(grp), 8'(opGroup));
		if (nb != 2'h0) chk("bytes", {6'h0, nb}, {6'h0, instrBytes});
		chk("acc", ea, accumulator);
		chk("zero", {7'h0, ez}, {7'h0, zeroFlag});
		chk("carry", {7'h0, ec}, {7'h0, carryFlag});
		pc = pc + 12'h004;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_immediate;
		run(4'h1, 4'h0, 8'hf0, 8'h00, 1'b0, 2'h0, 8'h00, 2'h2, 8'hf0, 1'b0, 1'b0);
		run(4'h2, 4'h0, 8'h20, 8'h00, 1'b0, 2'h0, 8'h00, 2'h2, 8'h10, 1'b0, 1'b1);
		run(4'h1, 4'h0, 8'h00, 8'h00, 1'b0, 2'h0, 8'h00, 2'h2, 8'h00, 1'b1, 1'b1);
		run(4'h5, 4'h0, 8'h01, 8'h00, 1'b0, 2'h0, 8'h00, 2'h2, 8'hff, 1'b0, 1'b1);
		run(4'h4, 4'h0, 8'hff, 8'h00, 1'b0, 2'h0, 8'h00, 2'h2, 8'hff, 1'b1, 1'b0);
		run(4'h3, 4'h0, 8'h0f, 8'h00, 1'b0, 2'h0, 8'h00, 2'h2, 8'h0f, 1'b0, 1'b0);
	endtask

	task automatic t_accum;
		run(4'h9, 4'h8, 8'h00, 8'h00, 1'b0, 2'h0, 8'h00, 2'h1, 8'hf0, 1'b0, 1'b0);
		run(4'hb, 4'h8, 8'h00, 8'h00, 1'b0, 2'h0, 8'h00, 2'h2, 8'he0, 1'b0, 1'b1);
		run(4'ha, 4'h8, 8'h00, 8'h00, 1'b0, 2'h0, 8'h00, 2'h1, 8'hc1, 1'b0, 1'b1);
	endtask

	task automatic t_memory;
		run(4'h1, 4'h0, 8'h40, 8'hfe, 1'b1, 2'h0, 8'h00, 2'h3, 8'hc1, 1'b0, 1'b1);
		chk("ram40", 8'hfe, mem.ram[8'h40]);
		run(4'h7, 4'h1, 8'h40, 8'h00, 1'b1, 2'h0, 8'h00, 2'h2, 8'hc1, 1'b0, 1'b1);
		chk("ram40", 8'hff, mem.ram[8'h40]);
		run(4'h6, 4'h1, 8'h40, 8'h00, 1'b1, 2'h0, 8'h00, 2'h3, 8'hc1, 1'b0, 1'b1);
		chk("ram40", 8'h00, mem.ram[8'h40]);
		mem.ram[8'h83] = 8'h01;
		run(4'h8, 4'h2, 8'h00, 8'h00, 1'b1, 2'h3, 8'h00, 2'h1, 8'hc1, 1'b1, 1'b1);
		chk("ram83", 8'h00, mem.ram[8'h83]);
		mem.ram[8'h50] = 8'h5a;
		run(4'h0, 4'h1, 8'h50, 8'h00, 1'b1, 2'h0, 8'h00, 2'h2, 8'hc1, 1'b0, 1'b1);
		chk("ram50", 8'hc1, mem.ram[8'h50]);
	endtask

	task automatic t_short;
		for (int i = 0; i < 4; i++) begin
			mem.ram[8'h80 + i] = 8'(8'h90 + i);
			run(4'h0, 4'h2, 8'h00, 8'h00, 1'b0, 2'(i), 8'h00, 2'h1, 8'(8'h90 + i), 1'b0, 1'b1);
		end
	endtask

	task automatic t_indirect;
		{mem.ram[8'h80], mem.ram[8'h81], mem.ram[8'h10], mem.ram[8'h20]} = 32'h1020a500;
		run(4'h0, 4'h7, 8'h00, 8'h00, 1'b0, 2'h0, 8'h07, 2'h1, 8'ha5, 1'b0, 1'b1);
		run(4'h0, 4'h7, 8'h00, 8'h00, 1'b0, 2'h0, 8'h17, 2'h1, 8'h00, 1'b1, 1'b1);
	endtask

	// Unary operations on the accumulator, then memory operands and an indirect store.
	task automatic t_acc_unary;
		run(4'h7, 4'h1, 8'h00, 8'h00, 1'b0, 2'h0, 8'h00, 2'h2, 8'h01, 1'b0, 1'b1);
		run(4'h6, 4'h2, 8'h00, 8'h00, 1'b0, 2'h0, 8'h00, 2'h2, 8'h00, 1'b1, 1'b0);
		run(4'h8, 4'h1, 8'h00, 8'h00, 1'b0, 2'h0, 8'h00, 2'h2, 8'hff, 1'b0, 1'b0);
		run(4'h2, 4'h1, 8'h50, 8'h00, 1'b0, 2'h0, 8'h00, 2'h2, 8'hc0, 1'b0, 1'b1);
		run(4'h0, 4'h7, 8'h00, 8'h00, 1'b1, 2'h0, 8'h17, 2'h1, 8'hc0, 1'b0, 1'b1);
		chk("ram20", 8'hc0, mem.ram[8'h20]);
		run(4'h4, 4'h7, 8'h00, 8'h00, 1'b0, 2'h0, 8'h07, 2'h1, 8'hc0, 1'b0, 1'b0);
	endtask

	initial begin
		repeat (2000) @(posedge core_clk);
		errors++;
		test_done();
	end

	initial begin
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		t_immediate();
		t_accum();
		t_memory();
		t_short();
		t_indirect();
		t_acc_unary();
		test_done();
	end
endmodule

/* File: mem_partner.sv */
`timescale 1ns/1ps
module mem_partner (
	// Clock
	input wire logic         core_clk,
	// Program ROM
	input wire logic [11:0]  romAddr,
	output logic [7:0]       romData,
	// Data space
	input wire logic [7:0]   dataAddr,
	input wire logic         dataRead,
	output logic [7:0]       dataRdata,
	input wire logic         dataWrite,
	input wire logic [7:0]   dataWdata
);
	logic [7:0] rom [4096];
	logic [7:0] ram [256];
	logic [7:0] lastRead_q = 8'h00;

	assign romData = rom[romAddr];
	// An idle data bus shows the inverse of its last value, so a stale read never matches.
	assign dataRdata = dataRead ? ram[dataAddr] : ~lastRead_q;

	always @(posedge core_clk) begin
		if (dataWrite) ram[dataAddr] <= dataWdata;
		if (dataRead) lastRead_q <= ram[dataAddr];
	end
endmodule
